// ---- core/scpm_cap_if.sv ----
/*
 interface carrying the capture flag and captured count from the timer
 channel to the monitor sequencer. single clock domain.
*/
`timescale 1ns/1ps
interface scpm_cap_if;
   logic capFlag;
   logic [scpm_pkg::CNT_W-1:0] capCount;
   modport timer (output capFlag, output capCount);
   modport mon (input capFlag, input capCount);
endinterface

// ---- core/scpm_capture_timer.sv ----
/*
 run-gated capture timer: while run is high, counts system clocks and latches the count on
 each rising edge of the selected reference. assumes refIn is already
 synchronous to ref_clk.
*/
`timescale 1ns/1ps
module scpm_capture_timer
   import scpm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic run,
   input wire logic refIn,
   scpm_cap_if.timer cap
);
   logic [CNT_W-1:0] cnt_r;
   logic refPrev_r;
   logic edgeSeen;

   assign edgeSeen = refIn & ~refPrev_r;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         refPrev_r <= 1'b0;
      end else begin
         refPrev_r <= refIn;
      end
   end

   // count restarts at every capture so the latched value is one period
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= '0;
         cap.capCount <= '0;
         cap.capFlag <= 1'b0;
      end else begin
         cap.capFlag <= run & edgeSeen;
         if (!run) begin
            cnt_r <= '0;
         end else if (edgeSeen) begin
            cap.capCount <= cnt_r + CNT_W'(1);
            cnt_r <= '0;
         end else if (cnt_r != '1) begin
            cnt_r <= cnt_r + CNT_W'(1);
         end
      end
   end

   a_capture_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cap.capFlag |=> !cap.capFlag)
      else $error("capture flag longer than one cycle");
endmodule

// ---- core/scpm_monitor.sv ----
/*
 system clock period monitor top: selects a reference source, captures its
 period in system clocks and judges it against a window. assumes all
 reference inputs are synchronous to ref_clk and start is a pulse.
*/
`timescale 1ns/1ps
module scpm_monitor
   import scpm_pkg::*;
#(
   parameter logic [CNT_W-1:0] TIMEOUT = TIMEOUT_RST
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic useEventLink,
   input wire logic [2:0] capture_source_select_a,
   input wire logic [2:0] capture_source_select_b,
   input wire logic ext_capture_pin_ch5,
   input wire logic ext_capture_pin_ch1,
   input wire logic low_speed_osc_clock,
   input wire logic subsystem_crystal_clock,
   input wire logic peripheralUsesSub,
   input wire logic [scpm_pkg::CNT_W-1:0] upper_period_limit,
   input wire logic [scpm_pkg::CNT_W-1:0] lower_period_limit,
   output logic busy,
   output logic done,
   output logic [1:0] result,
   output logic [scpm_pkg::CNT_W-1:0] periodCount
);
   import scpm_pkg::*;

   scpm_cap_if capBus();
   scpm_state_t state_r;
   logic [CNT_W-1:0] wait_r;
   logic low_speed_peripheral_clock;
   logic [1:0] cellSel;
   logic cellOut;
   logic refCh5;
   logic refCh1;
   logic refSel;
   logic timedOut;
   logic inWindow;

   function automatic logic direct_src(input logic [2:0] code, input logic pin,
                                       input logic sub, input logic osc);
      if (code == SEL_EXT_PIN) begin
         return pin;
      end else if (code == SEL_SUB_XTAL) begin
         return sub;
      end
      return osc;
   endfunction

   assign low_speed_peripheral_clock = peripheralUsesSub ? subsystem_crystal_clock : low_speed_osc_clock;
   assign cellSel = LB1_CELL0;
   // event link cell 0 of block 1 is a plain pass-through of its input
   assign cellOut = (cellSel == LB1_CELL0) ? low_speed_peripheral_clock : 1'b0;
   assign refCh5 = direct_src(capture_source_select_a, ext_capture_pin_ch5,
                              subsystem_crystal_clock, low_speed_osc_clock);
   assign refCh1 = (capture_source_select_b == SEL_EXT_PIN) ? ext_capture_pin_ch1 : cellOut;
   assign refSel = useEventLink ? refCh1 : refCh5;
   assign timedOut = (wait_r >= TIMEOUT);
   assign inWindow = (capBus.capCount <= upper_period_limit) &&
                     (capBus.capCount >= lower_period_limit);

   scpm_capture_timer u_timer (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .run(state_r == SCPM_SYNC || state_r == SCPM_MEAS),
      .refIn(refSel),
      .cap(capBus.timer)
   );

   // sequencer: a new start while busy is ignored
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= SCPM_IDLE;
      end else begin
         case (state_r)
            SCPM_IDLE, SCPM_DONE: begin
               if (start) begin
                  state_r <= SCPM_SYNC;
               end
            end
            SCPM_SYNC: begin
               if (capBus.capFlag) begin
                  state_r <= SCPM_MEAS;
               end else if (timedOut) begin
                  state_r <= SCPM_DONE;
               end
            end
            SCPM_MEAS: begin
               if (capBus.capFlag || timedOut) begin
                  state_r <= SCPM_DONE;
               end
            end
            default: state_r <= SCPM_IDLE;
         endcase
      end
   end

   // wait counter restarts on each capture so the bound applies per period
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_r <= '0;
      end else if ((state_r != SCPM_SYNC && state_r != SCPM_MEAS) || capBus.capFlag) begin
         wait_r <= '0;
      end else if (!timedOut) begin
         wait_r <= wait_r + CNT_W'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         result <= RES_PASS;
         periodCount <= '0;
         done <= 1'b0;
         busy <= 1'b0;
      end else begin
         done <= 1'b0;
         busy <= (state_r == SCPM_SYNC || state_r == SCPM_MEAS) ||
                 ((state_r == SCPM_IDLE || state_r == SCPM_DONE) && start);
         if ((state_r == SCPM_SYNC || state_r == SCPM_MEAS) && !capBus.capFlag && timedOut) begin
            result <= RES_NO_REF;
            done <= 1'b1;
            busy <= 1'b0;
         end else if (state_r == SCPM_MEAS && capBus.capFlag) begin
            result <= inWindow ? RES_PASS : RES_OUT_LIMIT;
            periodCount <= capBus.capCount;
            done <= 1'b1;
            busy <= 1'b0;
         end
      end
   end

   sequence s_sync_cap;
      state_r == SCPM_SYNC && capBus.capFlag;
   endsequence
   sequence s_meas_cap;
      state_r == SCPM_MEAS && capBus.capFlag;
   endsequence

   a_two_capture_seq: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_meas_cap |=> done)
      else $error("evaluation missing after second capture");
   a_sync_no_eval: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_sync_cap |=> !done && state_r == SCPM_MEAS)
      else $error("first capture must not be evaluated");
   a_pass_window: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (s_meas_cap and inWindow) |=> result == RES_PASS)
      else $error("in-window count not passed");
   a_out_limits: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (s_meas_cap and (capBus.capCount > upper_period_limit)) |=> result == RES_OUT_LIMIT)
      else $error("over-limit count not flagged");
   a_below_limit: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (s_meas_cap and (capBus.capCount < lower_period_limit)) |=> result == RES_OUT_LIMIT)
      else $error("under-limit count not flagged");
   a_no_ref_timeout: assert property (@(posedge ref_clk) disable iff (!reset_n)
      state_r == SCPM_SYNC && timedOut && !capBus.capFlag |=> done && result == RES_NO_REF)
      else $error("missing reference not reported");
   a_src_direct: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !useEventLink && capture_source_select_a == SEL_SUB_XTAL |-> refSel == subsystem_crystal_clock)
      else $error("crystal source not routed");
   a_src_link: assert property (@(posedge ref_clk) disable iff (!reset_n)
      useEventLink && capture_source_select_b != SEL_EXT_PIN |-> refSel == low_speed_peripheral_clock)
      else $error("peripheral clock not routed");
   a_cell_route: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cellOut == low_speed_peripheral_clock)
      else $error("link cell not passing peripheral clock");
   a_period_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_meas_cap |=> periodCount == $past(capBus.capCount))
      else $error("captured period not reported");
   a_done_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
      done |=> !done)
      else $error("done held longer than one cycle");

   // software only polls done, so busy, done and the held result must agree
   sequence s_start_taken;
      (state_r == SCPM_IDLE || state_r == SCPM_DONE) && start;
   endsequence
   sequence s_meas_lost;
      state_r == SCPM_MEAS && timedOut && !capBus.capFlag;
   endsequence

   a_start_busy: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_start_taken |=> busy && state_r == SCPM_SYNC && !done)
      else $error("start not taken");
   a_busy_state: assert property (@(posedge ref_clk) disable iff (!reset_n)
      busy == (state_r == SCPM_SYNC || state_r == SCPM_MEAS))
      else $error("busy does not follow the measurement");
   a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
      state_r == SCPM_IDLE && !start |=> state_r == SCPM_IDLE && !busy)
      else $error("idle monitor started by itself");
   a_done_state: assert property (@(posedge ref_clk) disable iff (!reset_n)
      done |-> !busy && state_r == SCPM_DONE)
      else $error("done outside the finished state");
   a_eval_after_cap: assert property (@(posedge ref_clk) disable iff (!reset_n)
      done && result != RES_NO_REF |-> $past(capBus.capFlag) && $past(state_r) == SCPM_MEAS)
      else $error("result given without a second capture");
   a_meas_timeout: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_meas_lost |=> done && result == RES_NO_REF)
      else $error("reference lost while measuring not reported");
   a_result_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !done |-> $stable(result) && $stable(periodCount))
      else $error("result changed without done");
   a_count_only_meas: assert property (@(posedge ref_clk) disable iff (!reset_n)
      state_r != SCPM_MEAS |=> $stable(periodCount))
      else $error("period count changed outside a measurement");
   a_pass_in_window: assert property (@(posedge ref_clk) disable iff (!reset_n)
      done && result == RES_PASS |->
         periodCount <= $past(upper_period_limit) && periodCount >= $past(lower_period_limit))
      else $error("pass reported for a count outside the window");
   a_direct_pin: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !useEventLink && capture_source_select_a == SEL_EXT_PIN |-> refSel == ext_capture_pin_ch5)
      else $error("channel 5 pin not routed");
   a_link_pin: assert property (@(posedge ref_clk) disable iff (!reset_n)
      useEventLink && capture_source_select_b == SEL_EXT_PIN |-> refSel == ext_capture_pin_ch1)
      else $error("channel 1 pin not routed");
endmodule

// ---- core/scpm_pkg.sv ----
/*
 package for the system clock period monitor: result codes, source codes,
 state encoding and default limits. assumes a 125 MHz system clock.
*/
package scpm_pkg;
   localparam int CNT_W = 16;
   localparam logic [2:0] SEL_EXT_PIN = 3'h0;
   localparam logic [2:0] SEL_SUB_XTAL = 3'h5;
   localparam logic [1:0] RES_PASS = 2'h0;
   localparam logic [1:0] RES_OUT_LIMIT = 2'h1;
   localparam logic [1:0] RES_NO_REF = 2'h2;
   localparam logic [CNT_W-1:0] UPPER_LIMIT_RST = 16'h0fa0;
   localparam logic [CNT_W-1:0] LOWER_LIMIT_RST = 16'h0eb0;
   localparam logic [CNT_W-1:0] TIMEOUT_RST = 16'h2000;
   localparam logic [1:0] LB1_CELL0 = 2'h0;
   typedef enum logic [1:0] {
      SCPM_IDLE = 2'b00,
      SCPM_SYNC = 2'b01,
      SCPM_MEAS = 2'b11,
      SCPM_DONE = 2'b10
   } scpm_state_t;
endpackage

// ---- sim/scpm_ref_source.sv ----
/*
 behavioural reference oscillator for the clock monitor: a square wave of
 2*HALF system clocks. assumes it is clocked by ref_clk, as the monitor
 takes its references as synchronous inputs.
*/
`timescale 1ns/1ps
module scpm_ref_source #(
   parameter int HALF = 10
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic run,
   output logic wave
);
   int cnt;
   // a stopped oscillator parks low, as a dead reference would
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 0;
         wave <= 1'b0;
      end else if (!run) begin
         cnt <= 0;
         wave <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         wave <= ~wave;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// ---- sim/system_clock_period_monitor_bench.sv ----
/*
 self-checking bench for scpm_monitor: four references of distinct period,
 random limits, window edges and a dead reference.
 assumes TIMEOUT of 64 is above every reference period.
*/
`timescale 1ns/1ps
module system_clock_period_monitor_bench;
   import scpm_pkg::*;
   logic ref_clk, reset_n, start, useEventLink, peripheralUsesSub, run, pin5, pin1, osc, sub, busy, done;
   logic [2:0] selA, selB;
   logic [1:0] result;
   logic [CNT_W-1:0] upper, lower, periodCount;
   int fails, checked, cycles, lastP;
   int expQ[$];
   int lk[6] = '{0, 0, 0, 1, 1, 1};
   int sl[6] = '{0, 5, 6, 0, 2, 7};
   int ps[6] = '{0, 0, 0, 0, 1, 0};
   int pe[6] = '{20, 36, 28, 24, 36, 28};
   int lv[4] = '{20, 21, 10, 19};
   int hv[4] = '{20, 30, 19, 21};
   scpm_ref_source #(.HALF(10)) pin5_src (.ref_clk(ref_clk), .reset_n(reset_n), .run(run), .wave(pin5));
   scpm_ref_source #(.HALF(12)) pin1_src (.ref_clk(ref_clk), .reset_n(reset_n), .run(run), .wave(pin1));
   scpm_ref_source #(.HALF(14)) osc_src (.ref_clk(ref_clk), .reset_n(reset_n), .run(run), .wave(osc));
   scpm_ref_source #(.HALF(18)) sub_src (.ref_clk(ref_clk), .reset_n(reset_n), .run(run), .wave(sub));
   scpm_monitor #(.TIMEOUT(16'h0040)) scpm_monitor_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .start(start), .useEventLink(useEventLink), .capture_source_select_a(selA),
      .capture_source_select_b(selB), .ext_capture_pin_ch5(pin5), .ext_capture_pin_ch1(pin1),
      .low_speed_osc_clock(osc), .subsystem_crystal_clock(sub), .peripheralUsesSub(peripheralUsesSub),
      .upper_period_limit(upper), .lower_period_limit(lower), .busy(busy), .done(done),
      .result(result), .periodCount(periodCount));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // p of 0 stands for a dead reference
   task automatic measure(input int p, input int lo, input int hi);
      int n;
      int expRes;
      expQ.push_back((p == 0) ? 2 : ((p >= lo && p <= hi) ? 0 : 1));
      lower = lo[CNT_W-1:0];
      upper = hi[CNT_W-1:0];
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      check("busy", {15'h0, busy}, 16'h1);
      n = 0;
      while (done !== 1'b1 && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      check("done", {15'h0, done}, 16'h1);
      check("busy", {15'h0, busy}, 16'h0);
      expRes = expQ.pop_front();
      check("result", {14'h0, result}, expRes[15:0]);
      if (p != 0)
         lastP = p;
      check("periodCount", periodCount, lastP[15:0]);
      @(negedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      // generous ceiling: the whole run needs under a thousand cycles
      if (cycles == 20000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      {reset_n, start, useEventLink, peripheralUsesSub, selA, selB} = '0;
      {upper, lower, fails, checked, cycles, lastP} = '0;
      run = 1'b1;
      void'($urandom(32'h3ce5689f));
      repeat (20) @(negedge ref_clk);
      reset_n = 1'b1;
      check("busy", {15'h0, busy}, 16'h0);
      for (int k = 0; k < 6; k++) begin
         useEventLink = lk[k][0];
         selA = lk[k] ? 3'($urandom) : sl[k][2:0];
         selB = lk[k] ? sl[k][2:0] : 3'($urandom);
         peripheralUsesSub = lk[k] ? ps[k][0] : 1'($urandom);
         measure(pe[k], pe[k] - 4 + int'($urandom % 9), pe[k] - 4 + int'($urandom % 9));
         $display("source case %0d finished", k);
      end
      useEventLink = 1'b0;
      selA = SEL_EXT_PIN;
      for (int j = 0; j < 4; j++)
         measure(20, lv[j], hv[j]);
      $display("window edges finished");
      run = 1'b0;
      measure(0, 0, 100);
      run = 1'b1;
      measure(20, 0, 100);
      $display("dead reference finished");
      // reset in mid measurement must leave the monitor idle with cleared results
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      repeat (15) @(negedge ref_clk);
      check("busy", {15'h0, busy}, 16'h1);
      reset_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      reset_n = 1'b1;
      check("busy", {15'h0, busy}, 16'h0);
      check("done", {15'h0, done}, 16'h0);
      check("result", {14'h0, result}, 16'h0);
      check("periodCount", periodCount, 16'h0);
      lastP = 0;
      measure(20, 0, 100);
      $display("mid-run reset finished");
      wrap_up();
   end
endmodule
